// ### common/pcg_cfg.svh
// Purpose: constants for the pwm and contrast pulse generator
// Assumes: included by bare name
// Notes: definitions only
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH
`define PCG_EXP_W 4
`define PCG_EXP_MAX 4'hC
`define PCG_DIV_W 12
`define PCG_DUTY_W 8
`define PCG_BURST_W 9
`define PCG_BURST_MAX 9'h100
`define PCG_FRAME_LAST 8'hFF
`endif

// ### common/pcg_pkg.sv
// Purpose: types for the pwm and contrast pulse generator
// Assumes: nothing
// Notes: clock source type shared by both channels, each with its own select
package pcg_pkg;
  typedef enum logic {PCG_SRC_PRIMARY, PCG_SRC_SECONDARY} pcg_src_type;
  typedef enum logic [1:0] {PCG_IDLE, PCG_HIGH, PCG_LOW, PCG_DONE} pcg_burst_type;
endpackage : pcg_pkg

// ### verilog/pcg_top.sv
// Purpose: pwm output and contrast pulse burst generator
// Assumes: clock inputs are slow pins, sampled on clk
// Notes: rising edges of the chosen source clock advance each channel
// ==========
`timescale 1ns/10ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_top
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic primary_clock_input,
  input wire logic secondary_clock_input,
  input wire pcg_pkg::pcg_src_type pwm_source_clock_select,
  input wire logic [`PCG_EXP_W-1:0] pwm_divider_exponent,
  input wire logic [`PCG_DUTY_W-1:0] high_time_count,
  input wire logic pwm_enable,
  input wire pcg_pkg::pcg_src_type cp_source_clock_select,
  input wire logic [`PCG_EXP_W-1:0] cp_divider_exponent,
  input wire logic [`PCG_BURST_W-1:0] pulse_burst_count,
  input wire logic cp_enable,
  input wire logic cp_start,
  output logic pwm_out,
  output logic contrast_pulse,
  output logic cp_busy
);
  // ==========
  // pin synchronisers and edge detect
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic prev_a;
  logic prev_b;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      prev_a <= 1'h0;
      prev_b <= 1'h0;
    end
    else
    begin
      sync_a <= {sync_a[0], primary_clock_input};
      sync_b <= {sync_b[0], secondary_clock_input};
      prev_a <= sync_a[1];
      prev_b <= sync_b[1];
    end
  end
  wire rise_a = sync_a[1] & ~prev_a;
  wire rise_b = sync_b[1] & ~prev_b;
  wire pwm_src_rise = (pwm_source_clock_select == pcg_pkg::PCG_SRC_SECONDARY) ? rise_b : rise_a;
  wire cp_src_rise = (cp_source_clock_select == pcg_pkg::PCG_SRC_SECONDARY) ? rise_b : rise_a;

  // ==========
  // power of two dividers
  logic [`PCG_DIV_W-1:0] pwm_div;
  logic [`PCG_DIV_W-1:0] cp_div;
  // exponents above 12 clamp to 12 rather than wrap
  wire [`PCG_EXP_W-1:0] pwm_exp = (pwm_divider_exponent > `PCG_EXP_MAX) ? `PCG_EXP_MAX
                                                                      : pwm_divider_exponent;
  wire [`PCG_EXP_W-1:0] cp_exp = (cp_divider_exponent > `PCG_EXP_MAX) ? `PCG_EXP_MAX
                                                                    : cp_divider_exponent;
  wire [`PCG_DIV_W:0] pwm_mask = ({{`PCG_DIV_W{1'h0}}, 1'h1} << pwm_exp) - 13'h1;
  wire [`PCG_DIV_W:0] cp_mask = ({{`PCG_DIV_W{1'h0}}, 1'h1} << cp_exp) - 13'h1;
  wire pwm_tick = pwm_src_rise &
                  ((pwm_div & pwm_mask[`PCG_DIV_W-1:0]) == pwm_mask[`PCG_DIV_W-1:0]);
  wire cp_tick = cp_src_rise & ((cp_div & cp_mask[`PCG_DIV_W-1:0]) == cp_mask[`PCG_DIV_W-1:0]);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwm_div <= 12'h000;
      cp_div <= 12'h000;
    end
    else
    begin
      if (!pwm_enable)
        pwm_div <= 12'h000;
      else if (pwm_src_rise)
        pwm_div <= pwm_div + 12'h001;
      if (!cp_enable)
        cp_div <= 12'h000;
      else if (cp_src_rise)
        cp_div <= cp_div + 12'h001;
    end
  end

  // ==========
  // pwm channel
  logic [`PCG_DUTY_W-1:0] pwm_phase;
  wire next_pwm_out = pwm_enable && (pwm_phase < high_time_count);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwm_phase <= 8'h00;
      pwm_out <= 1'h0;
    end
    else
    begin
      if (!pwm_enable)
        pwm_phase <= 8'h00;
      else if (pwm_tick)
        pwm_phase <= pwm_phase + 8'h01;
      pwm_out <= next_pwm_out;
    end
  end

  // ==========
  // contrast pulse burst channel
  pcg_pkg::pcg_burst_type cp_state;
  logic [`PCG_BURST_W-1:0] cp_left;
  // zero count taken as one; counts above 256 clamp
  wire [`PCG_BURST_W-1:0] cp_load = (pulse_burst_count == 9'h000) ? 9'h001 :
                                    (pulse_burst_count > `PCG_BURST_MAX) ? `PCG_BURST_MAX :
                                    pulse_burst_count;
  assign cp_busy = (cp_state != pcg_pkg::PCG_IDLE);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cp_state <= pcg_pkg::PCG_IDLE;
      cp_left <= 9'h000;
      contrast_pulse <= 1'h0;
    end
    else if (!cp_enable)
    begin
      cp_state <= pcg_pkg::PCG_IDLE;
      cp_left <= 9'h000;
      contrast_pulse <= 1'h0;
    end
    else
    begin
      unique case (cp_state)
        pcg_pkg::PCG_IDLE:
        begin
          if (cp_start)
          begin
            cp_left <= cp_load;
            cp_state <= pcg_pkg::PCG_DONE;
          end
        end
        pcg_pkg::PCG_DONE:
        begin
          // align first pulse to a divided tick
          if (cp_tick)
          begin
            contrast_pulse <= 1'h1;
            cp_state <= pcg_pkg::PCG_HIGH;
          end
        end
        pcg_pkg::PCG_HIGH:
        begin
          if (cp_tick)
          begin
            contrast_pulse <= 1'h0;
            cp_left <= cp_left - 9'h001;
            cp_state <= pcg_pkg::PCG_LOW;
          end
        end
        pcg_pkg::PCG_LOW:
        begin
          if (cp_tick)
          begin
            if (cp_left == 9'h000)
              cp_state <= pcg_pkg::PCG_IDLE;
            else
            begin
              contrast_pulse <= 1'h1;
              cp_state <= pcg_pkg::PCG_HIGH;
            end
          end
        end
      endcase
    end
  end

  // ==========
  // assertions
  sequence s_pwm_off;
    !pwm_enable;
  endsequence
  a_pwm_low_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_pwm_off |=> !pwm_out) else $error("pwm high while disabled");
  a_pwm_zero_low: assert property (@(posedge clk) disable iff (!rst_b)
    (high_time_count == 8'h00) |=> !pwm_out) else $error("pwm high with zero duty");
  a_pwm_full_high: assert property (@(posedge clk) disable iff (!rst_b)
    (pwm_enable && high_time_count == 8'hFF && pwm_phase != `PCG_FRAME_LAST) |=> pwm_out)
    else $error("pwm low at full duty");
  a_pwm_follows: assert property (@(posedge clk) disable iff (!rst_b)
    (pwm_enable && pwm_phase < high_time_count) |=> pwm_out) else $error("pwm missed high");
  a_div_tick_one: assert property (@(posedge clk) disable iff (!rst_b)
    (pwm_src_rise && pwm_exp == 4'h0) |-> pwm_tick) else $error("edge without tick");
  a_pwm_src_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (pwm_source_clock_select == pcg_pkg::PCG_SRC_PRIMARY && pwm_src_rise)
    |-> (sync_a[1] && !prev_a))
    else $error("pwm source wrong");
  a_cp_src_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (cp_source_clock_select == pcg_pkg::PCG_SRC_SECONDARY && cp_src_rise)
    |-> (sync_b[1] && !prev_b))
    else $error("contrast source wrong");
  a_cp_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !cp_enable |=> (!contrast_pulse && !cp_busy)) else $error("contrast active while off");
  a_cp_burst_end: assert property (@(posedge clk) disable iff (!rst_b)
    (cp_enable && cp_state == pcg_pkg::PCG_LOW && cp_tick && cp_left == 9'h000)
    |=> !cp_busy) else $error("burst did not end");
endmodule : pcg_top
`default_nettype wire

// ### dv/pcg_load_model.sv
// Purpose: load on the pwm and burst outputs
// Assumes: clk samples both outputs
// Notes: integrates high time, counts burst pulses
`timescale 1ns/10ps
`default_nettype none
module pcg_load_model
(
  input wire logic clk,
  input wire logic clr,
  input wire logic pwm_in,
  input wire logic cp_in,
  output int pwm_high,
  output int cp_high,
  output int cp_rises
);
  logic cp_last;
  // ==========
  // integrator, stands in for the rc filter
  always @(posedge clk)
  begin
    cp_last <= cp_in;
    pwm_high <= clr ? 0 : pwm_high + (pwm_in === 1'b1);
    cp_high <= clr ? 0 : cp_high + (cp_in === 1'b1);
    cp_rises <= clr ? 0 : cp_rises + (cp_in === 1'b1 && cp_last !== 1'b1);
  end
endmodule : pcg_load_model
`default_nettype wire

// ### dv/tb_pwm_and_contrast_pulse_gen.sv
// Purpose: self-checking bench for pcg_top
// Assumes: source clocks are 8 and 12 clk periods
// Notes: a full pwm frame holds exactly duty times tick length of high time
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_and_contrast_pulse_gen;
  localparam pcg_pkg::pcg_src_type pri = pcg_pkg::PCG_SRC_PRIMARY;
  localparam pcg_pkg::pcg_src_type sec = pcg_pkg::PCG_SRC_SECONDARY;
  logic clk = 1'b0, rst_b = 1'b0, src_a = 1'b0, src_b = 1'b0, clr = 1'b0;
  pcg_pkg::pcg_src_type pwm_sel = pri, cp_sel = pri;
  logic [3:0] pwm_exp = 4'h0, cp_exp = 4'h0;
  logic [7:0] duty = 8'h00;
  logic [8:0] burst = 9'h001;
  logic pwm_en = 1'b0, cp_en = 1'b0, cp_go = 1'b0;
  wire logic pwm_out, cp_out, cp_busy;
  int pwm_high, cp_high, cp_rises, errors = 0, checked = 0, cycles = 0, na = 0, nb = 0;
  int unsigned seed = 45536;
  pcg_top dut_u (.clk(clk), .rst_b(rst_b), .primary_clock_input(src_a),
    .secondary_clock_input(src_b), .pwm_source_clock_select(pwm_sel),
    .pwm_divider_exponent(pwm_exp), .high_time_count(duty), .pwm_enable(pwm_en),
    .cp_source_clock_select(cp_sel), .cp_divider_exponent(cp_exp),
    .pulse_burst_count(burst), .cp_enable(cp_en), .cp_start(cp_go),
    .pwm_out(pwm_out), .contrast_pulse(cp_out), .cp_busy(cp_busy));
  pcg_load_model load_u (.clk(clk), .clr(clr), .pwm_in(pwm_out), .cp_in(cp_out),
    .pwm_high(pwm_high), .cp_high(cp_high), .cp_rises(cp_rises));
  // ==========
  // clocks and hang guard
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    na <= (na + 1) % 4;
    nb <= (nb + 1) % 6;
    if (na == 3) src_a <= ~src_a;
    if (nb == 5) src_b <= ~src_b;
    if (cycles == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input int got, input int exp);
    checked++;
    if (got !== exp) $display("[FAIL] %0t count %0d want %0d", $time, got, exp);
    if (got !== exp) errors++;
  endtask : check
  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) $display("[FAIL] %0t busy flag %b want %b", $time, got, exp);
    if (got !== exp) errors++;
  endtask : check_flag
  task automatic measure(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask : measure
  // ==========
  // model: frame is 256 ticks of source period shifted by exponent
  task automatic pwm_case(input logic [7:0] d, input pcg_pkg::pcg_src_type s,
    input logic [3:0] n, input logic en);
    int w;
    w = (256 * (s == pri ? 8 : 12)) << n;
    @(posedge clk);
    duty <= d;
    pwm_sel <= s;
    pwm_exp <= n;
    pwm_en <= 1'b0;
    @(posedge clk);
    pwm_en <= en;
    repeat (w / 128) @(posedge clk);
    measure(w);
    check(pwm_high, en ? d * w / 256 : 0);
  endtask : pwm_case
  task automatic cp_case(input logic [8:0] c, input pcg_pkg::pcg_src_type s,
    input logic [3:0] n, input logic en);
    int per, t, cnt;
    per = (s == pri ? 8 : 12) << n;
    t = 0;
    // zero counts as one pulse, above 256 clamps
    cnt = (c == 9'h000) ? 1 : ((c > 9'h100) ? 256 : int'(c));
    @(posedge clk);
    burst <= c;
    cp_sel <= s;
    cp_exp <= n;
    cp_en <= en;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cp_go <= 1'b1;
    @(posedge clk);
    cp_go <= 1'b0;
    #1 check_flag(cp_busy, en);
    // sample busy off the edge, never in its launch step
    while (cp_busy === 1'b1 && t < 2 * cnt * per + 8 * per)
    begin
      @(posedge clk);
      #1 t++;
    end
    check_flag(cp_busy, 1'b0);
    repeat (2) @(posedge clk);
    #1 check(cp_rises, en ? cnt : 0);
    check(cp_high, en ? cnt * per : 0);
  endtask : cp_case
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    pwm_case(8'h00, pri, 4'h0, 1'b1);
    pwm_case(8'hFF, sec, 4'h1, 1'b1);
    pwm_case(8'(rnd()), pri, 4'h1, 1'b1);
    pwm_case(8'hFF, pri, 4'h0, 1'b0);
    cp_case(9'h001, pri, 4'h0, 1'b1);
    cp_case(9'h100, sec, 4'h0, 1'b1);
    cp_case(9'(rnd() % 255 + 2), pri, 4'h2, 1'b1);
    cp_case(9'h005, sec, 4'h0, 1'b0);
    cp_case(9'h000, pri, 4'h0, 1'b1);
    cp_case(9'h1FF, pri, 4'h0, 1'b1);
    report_and_stop();
  end
endmodule : tb_pwm_and_contrast_pulse_gen
`default_nettype wire
